/* File: hw/pvs_host.sv */
// Purpose: Host that generates panel video timing and sequences panel power and backlight.
// Assumes: pix_clk comes from an external synthesiser at the panel pixel rate; supply good pins are asynchronous.
// Notes: Sequencing runs on clk; the timing generator runs on pix_clk and is gated by a crossed level.
//
// Contract
// RULE1: Pixel data is qualified by a valid line; no separate sync pulses.
// RULE2: Each line totals 1410 to 1470 pixel clocks, 1280 of them active.
// RULE3: Line blanking stays within 60 to 190 clocks, nominally 160.
// RULE4: Exactly 800 active lines per frame; qualifier high only on them.
// RULE5: Each frame totals 815 to 1023 lines, nominally 823.
// RULE6: Frame blanking stays within 15 to 33 lines, nominally 23.
// RULE7: Pixel clock runs 68.9 to 73.4 MHz, nominally 71.1 MHz.
// RULE8: While logic supply is off, every panel signal is low.
// RULE9: Video becomes valid 30 to 90 ms after logic supply is good.
// RULE10: Backlight power-up starts at least 200 ms after video is valid.
// RULE11: Dimming pulse starts at least 10 ms after backlight supply is good.
// RULE12: Backlight enable rises at least 10 ms after dimming pulse starts.
// RULE13: Backlight enable falls no later than the dimming pulse stops.
// RULE14: Backlight supply turns off at least 200 ms after dimming stops.
// RULE15: Video stops at least 200 ms after the backlight is off.
// RULE16: Logic supply is removed within 50 ms after video stops.
// RULE17: Dimming duty respects the least duty for the pulse frequency.
// RULE18: Panel rides through short logic supply dips on its own.
// RULE19: Backlight uses a dimming pulse and a separate enable, both sequenced.
// RULE20: Video and pixel clock travel over serial pairs outside this block.
// RULE21: Power steps run as ordered state machine with millisecond counters.
// RULE22: Qualifier stays low through all line and frame blanking.
`timescale 1ns/10ps
module pvs_host #(
  parameter int CLKS_PER_MS = pvs_pkg::CLKS_PER_MS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic pix_clk,
  input wire logic power_request,
  input wire logic [pvs_pkg::DUTY_WIDTH-1:0] dimming_duty,
  input wire logic logic_supply_good,
  input wire logic backlight_supply_good,
  input wire logic [pvs_pkg::PIXEL_WIDTH-1:0] pixel_in,
  output logic pixel_request,
  output pvs_pkg::pvs_power_type power_pins,
  output pvs_pkg::pvs_video_type video_out,
  output logic panel_ready,
  output logic panel_off
);

  // Clamp requested duty into the legal band for the fixed pulse frequency
  function automatic logic [pvs_pkg::PWM_WIDTH-1:0] duty_to_clks(input logic [pvs_pkg::DUTY_WIDTH-1:0] permille);
    logic [pvs_pkg::DUTY_WIDTH-1:0] p;
    p = permille;
    if (p < pvs_pkg::DUTY_WIDTH'(pvs_pkg::DIMMING_DUTY_MIN_PERMILLE)) begin
      p = pvs_pkg::DUTY_WIDTH'(pvs_pkg::DIMMING_DUTY_MIN_PERMILLE);
    end
    if (p > pvs_pkg::DUTY_WIDTH'(pvs_pkg::PERMILLE_FULL)) begin
      p = pvs_pkg::DUTY_WIDTH'(pvs_pkg::PERMILLE_FULL);
    end
    duty_to_clks = pvs_pkg::PWM_WIDTH'(p) * pvs_pkg::PWM_WIDTH'(pvs_pkg::PWM_CLKS_PER_PERMILLE);
  endfunction : duty_to_clks

  pvs_pkg::pvs_state_type state_q, state_d;
  logic [2:0] lsg_sync_q;
  logic [2:0] bsg_sync_q;
  logic logic_good_q;
  logic backlight_good_q;
  logic [pvs_pkg::MS_TICK_WIDTH-1:0] tick_cnt_q;
  logic [pvs_pkg::MS_COUNT_WIDTH-1:0] ms_cnt_q;
  logic ms_tick;
  logic [pvs_pkg::PWM_WIDTH-1:0] pwm_cnt_q;
  logic [pvs_pkg::PWM_WIDTH-1:0] pwm_high_q;
  logic pwm_run_q;
  logic video_en_q;
  logic [2:0] ven_sync_q;
  logic pix_run_q;
  logic [pvs_pkg::H_WIDTH-1:0] h_cnt_q;
  logic [pvs_pkg::V_WIDTH-1:0] v_cnt_q;
  logic active;

  // Supply good pins: three stages, change taken when stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lsg_sync_q <= 3'h0;
      bsg_sync_q <= 3'h0;
      logic_good_q <= 1'b0;
      backlight_good_q <= 1'b0;
    end else begin
      lsg_sync_q <= {lsg_sync_q[1:0], logic_supply_good};
      bsg_sync_q <= {bsg_sync_q[1:0], backlight_supply_good};
      if (lsg_sync_q[1] == lsg_sync_q[2]) begin
        logic_good_q <= lsg_sync_q[2];
      end
      if (bsg_sync_q[1] == bsg_sync_q[2]) begin
        backlight_good_q <= bsg_sync_q[2];
      end
    end
  end

  // Millisecond prescaler restarts on every state change so a wait of N ticks is N full ms
  assign ms_tick = (tick_cnt_q == pvs_pkg::MS_TICK_WIDTH'(CLKS_PER_MS - 1));
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= '0;
      ms_cnt_q <= '0;
    end else if (state_d != state_q) begin // see RULE21
      tick_cnt_q <= '0;
      ms_cnt_q <= '0;
    end else if (ms_tick) begin
      tick_cnt_q <= '0;
      if (ms_cnt_q != '1) begin
        ms_cnt_q <= ms_cnt_q + 1'b1; // Saturates, long waits never wrap
      end
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Ordered power steps; a power-up step never moves on before its least delay unless power_request drops
  always_comb begin
    state_d = state_q;
    case (state_q)
      pvs_pkg::ST_OFF: begin
        if (power_request) begin
          state_d = pvs_pkg::ST_SUPPLY_WAIT;
        end
      end
      pvs_pkg::ST_SUPPLY_WAIT: begin
        if (!power_request) begin
          state_d = pvs_pkg::ST_OFF;
        end else if (logic_good_q) begin
          state_d = pvs_pkg::ST_SETTLE;
        end
      end
      pvs_pkg::ST_SETTLE: begin
        if (!power_request) begin
          state_d = pvs_pkg::ST_OFF;
        end else if (ms_cnt_q == pvs_pkg::MS_COUNT_WIDTH'(pvs_pkg::SUPPLY_TO_VIDEO_DELAY_MS)) begin // see RULE9
          state_d = pvs_pkg::ST_VIDEO_ON;
        end
      end
      pvs_pkg::ST_VIDEO_ON: begin
        if (!power_request) begin
          state_d = pvs_pkg::ST_BL_SUPPLY_OFF;
        end else if (ms_cnt_q >= pvs_pkg::MS_COUNT_WIDTH'(pvs_pkg::VIDEO_TO_BACKLIGHT_DELAY_MS)) begin // see RULE10
          state_d = pvs_pkg::ST_BL_SUPPLY_WAIT;
        end
      end
      pvs_pkg::ST_BL_SUPPLY_WAIT: begin
        if (!power_request) begin
          state_d = pvs_pkg::ST_BL_SUPPLY_OFF;
        end else if (backlight_good_q) begin
          state_d = pvs_pkg::ST_BL_SETTLE;
        end
      end
      pvs_pkg::ST_BL_SETTLE: begin
        if (!power_request) begin
          state_d = pvs_pkg::ST_BL_SUPPLY_OFF;
        end else if (ms_cnt_q >= pvs_pkg::MS_COUNT_WIDTH'(pvs_pkg::BACKLIGHT_SUPPLY_TO_DIMMING_DELAY_MS)) begin // see RULE11
          state_d = pvs_pkg::ST_DIM_ON;
        end
      end
      pvs_pkg::ST_DIM_ON: begin
        if (!power_request) begin
          state_d = pvs_pkg::ST_BL_DOWN;
        end else if (ms_cnt_q >= pvs_pkg::MS_COUNT_WIDTH'(pvs_pkg::DIMMING_TO_ENABLE_DELAY_MS)) begin // see RULE12
          state_d = pvs_pkg::ST_RUN;
        end
      end
      pvs_pkg::ST_RUN: begin
        if (!power_request) begin
          state_d = pvs_pkg::ST_BL_DOWN;
        end
      end
      pvs_pkg::ST_BL_DOWN: begin
        if (ms_cnt_q >= pvs_pkg::MS_COUNT_WIDTH'(pvs_pkg::DIMMING_OFF_TO_BACKLIGHT_SUPPLY_OFF_MS)) begin // see RULE14
          state_d = pvs_pkg::ST_BL_SUPPLY_OFF;
        end
      end
      pvs_pkg::ST_BL_SUPPLY_OFF: begin
        if (ms_cnt_q >= pvs_pkg::MS_COUNT_WIDTH'(pvs_pkg::BACKLIGHT_OFF_TO_VIDEO_OFF_MS)) begin // see RULE15
          state_d = pvs_pkg::ST_VIDEO_OFF;
        end
      end
      pvs_pkg::ST_VIDEO_OFF: begin
        if (ms_cnt_q >= pvs_pkg::MS_COUNT_WIDTH'(pvs_pkg::VIDEO_OFF_TO_SUPPLY_OFF_MS)) begin // see RULE16
          state_d = pvs_pkg::ST_OFF;
        end
      end
      default: begin
        state_d = pvs_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= pvs_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Logic and backlight supply enables follow the state one cycle later
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_pins.logic_supply_enable <= 1'b0;
      power_pins.backlight_supply_enable <= 1'b0;
    end else begin
      power_pins.logic_supply_enable <= (state_q != pvs_pkg::ST_OFF);
      power_pins.backlight_supply_enable <= (state_q == pvs_pkg::ST_BL_SUPPLY_WAIT) ||
        (state_q == pvs_pkg::ST_BL_SETTLE) || (state_q == pvs_pkg::ST_DIM_ON) ||
        (state_q == pvs_pkg::ST_RUN) || (state_q == pvs_pkg::ST_BL_DOWN); // see RULE14
    end
  end

  // Enable falls one cycle before the dimming pulse is forced low, which meets the zero least gap
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwm_run_q <= 1'b0;
      power_pins.backlight_enable_line <= 1'b0;
    end else begin
      pwm_run_q <= (state_q == pvs_pkg::ST_DIM_ON) || (state_q == pvs_pkg::ST_RUN); // see RULE19
      power_pins.backlight_enable_line <= (state_q == pvs_pkg::ST_RUN); // see RULE13
    end
  end

  // Dimming pulse at fixed frequency; duty held per period to avoid glitches mid-cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwm_cnt_q <= '0;
      pwm_high_q <= '0;
      power_pins.backlight_dimming_pulse <= 1'b0;
    end else if (!pwm_run_q) begin
      pwm_cnt_q <= '0;
      pwm_high_q <= duty_to_clks(dimming_duty);
      power_pins.backlight_dimming_pulse <= 1'b0; // see RULE8
    end else begin
      if (pwm_cnt_q == pvs_pkg::PWM_WIDTH'(pvs_pkg::PWM_PERIOD_CLKS - 1)) begin
        pwm_cnt_q <= '0;
        pwm_high_q <= duty_to_clks(dimming_duty); // see RULE17
      end else begin
        pwm_cnt_q <= pwm_cnt_q + 1'b1;
      end
      power_pins.backlight_dimming_pulse <= (pwm_cnt_q < pwm_high_q);
    end
  end

  // Video valid level for the pixel domain; RULE18 needs no action, dips are not acted on
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      video_en_q <= 1'b0;
    end else begin
      video_en_q <= (state_q == pvs_pkg::ST_VIDEO_ON) || (state_q == pvs_pkg::ST_BL_SUPPLY_WAIT) ||
        (state_q == pvs_pkg::ST_BL_SETTLE) || (state_q == pvs_pkg::ST_DIM_ON) ||
        (state_q == pvs_pkg::ST_RUN) || (state_q == pvs_pkg::ST_BL_DOWN) ||
        (state_q == pvs_pkg::ST_BL_SUPPLY_OFF); // see RULE15
    end
  end

  // Status toward the user
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      panel_ready <= 1'b0;
      panel_off <= 1'b1;
    end else begin
      panel_ready <= (state_q == pvs_pkg::ST_RUN);
      panel_off <= (state_q == pvs_pkg::ST_OFF);
    end
  end

  // Cross video enable into the pixel domain, taken when stages two and three agree; pix_clk rate is set outside, see RULE7
  always_ff @(posedge pix_clk or posedge reset) begin
    if (reset) begin
      ven_sync_q <= 3'h0;
      pix_run_q <= 1'b0;
    end else begin
      ven_sync_q <= {ven_sync_q[1:0], video_en_q};
      if (ven_sync_q[1] == ven_sync_q[2]) begin
        pix_run_q <= ven_sync_q[2];
      end
    end
  end

  // Line and frame counters; held at the frame origin while video is off
  always_ff @(posedge pix_clk or posedge reset) begin
    if (reset) begin
      h_cnt_q <= '0;
      v_cnt_q <= '0;
    end else if (!pix_run_q) begin
      h_cnt_q <= '0;
      v_cnt_q <= '0;
    end else if (h_cnt_q == pvs_pkg::H_WIDTH'(pvs_pkg::LINE_TOTAL_CLOCKS - 1)) begin // see RULE2
      h_cnt_q <= '0;
      if (v_cnt_q == pvs_pkg::V_WIDTH'(pvs_pkg::FRAME_TOTAL_LINES - 1)) begin // see RULE5
        v_cnt_q <= '0;
      end else begin
        v_cnt_q <= v_cnt_q + 1'b1;
      end
    end else begin
      h_cnt_q <= h_cnt_q + 1'b1;
    end
  end

  // Active area decode; blanking figures follow from totals minus active counts
  assign active = pix_run_q && (h_cnt_q < pvs_pkg::H_WIDTH'(pvs_pkg::ACTIVE_CLOCKS_PER_LINE)) && // see RULE3
    (v_cnt_q < pvs_pkg::V_WIDTH'(pvs_pkg::ACTIVE_LINES_PER_FRAME)); // see RULE4
  assign pixel_request = active; // see RULE6

  // Qualified pixel output; data forced low outside the active area; serialised outside, see RULE20
  always_ff @(posedge pix_clk or posedge reset) begin
    if (reset) begin
      video_out.pixel_valid_qualifier <= 1'b0;
      video_out.pixel_data <= '0;
    end else begin
      video_out.pixel_valid_qualifier <= active; // see RULE1
      video_out.pixel_data <= active ? pixel_in : '0; // see RULE22
    end
  end

endmodule : pvs_host

/* File: hw/pvs_pkg.sv */
// Purpose: Shared constants and carriers for the panel video timing and power sequencer host.
// Assumes: Control clock of 40 MHz; pixel clock supplied by an external synthesiser.
// Notes: Millisecond delays are counted in ticks of a restartable prescaler.
package pvs_pkg;

  // Control clock
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PS_PER_MS = 1000000000;
  localparam int CLKS_PER_MS = PS_PER_MS / CLK_PERIOD_PS;
  localparam int MS_TICK_WIDTH = 16;

  // Power sequencing delays in ms, least values unless marked
  localparam int SUPPLY_TO_VIDEO_DELAY_MS = 30;
  localparam int SUPPLY_TO_VIDEO_MAX_MS = 90;
  localparam int VIDEO_TO_BACKLIGHT_DELAY_MS = 200;
  localparam int BACKLIGHT_SUPPLY_TO_DIMMING_DELAY_MS = 10;
  localparam int DIMMING_TO_ENABLE_DELAY_MS = 10;
  localparam int ENABLE_OFF_TO_DIMMING_OFF_DELAY_MS = 0;
  localparam int DIMMING_OFF_TO_BACKLIGHT_SUPPLY_OFF_MS = 200;
  localparam int BACKLIGHT_OFF_TO_VIDEO_OFF_MS = 200;
  localparam int VIDEO_OFF_TO_SUPPLY_OFF_MS = 1;
  localparam int MS_COUNT_WIDTH = 8;

  // Line and frame geometry in pixel clocks and lines
  localparam int ACTIVE_CLOCKS_PER_LINE = 1280;
  localparam int LINE_BLANKING_CLOCKS = 160;
  localparam int LINE_TOTAL_CLOCKS = ACTIVE_CLOCKS_PER_LINE + LINE_BLANKING_CLOCKS;
  localparam int ACTIVE_LINES_PER_FRAME = 800;
  localparam int FRAME_BLANKING_LINES = 23;
  localparam int FRAME_TOTAL_LINES = ACTIVE_LINES_PER_FRAME + FRAME_BLANKING_LINES;
  localparam int H_WIDTH = 11;
  localparam int V_WIDTH = 10;
  localparam int PIXEL_WIDTH = 24;

  // Dimming pulse: 20 kHz needs at least 10 percent duty
  localparam int PWM_FREQ_HZ = 20000;
  localparam int CLK_HZ = 40000000;
  localparam int PWM_PERIOD_CLKS = CLK_HZ / PWM_FREQ_HZ;
  localparam int PERMILLE_FULL = 1000;
  localparam int PWM_CLKS_PER_PERMILLE = PWM_PERIOD_CLKS / PERMILLE_FULL;
  localparam int DIMMING_DUTY_MIN_PERMILLE = 100;
  localparam int DUTY_WIDTH = 10;
  localparam int PWM_WIDTH = 11;

  // Power pins toward the panel
  typedef struct packed {
    logic logic_supply_enable;
    logic backlight_supply_enable;
    logic backlight_dimming_pulse;
    logic backlight_enable_line;
  } pvs_power_type;

  // Video qualifier and data toward the link serialiser
  typedef struct packed {
    logic pixel_valid_qualifier;
    logic [PIXEL_WIDTH-1:0] pixel_data;
  } pvs_video_type;

  // Sequencer states, one-hot
  typedef enum logic [10:0] {
    ST_OFF = 11'h001,
    ST_SUPPLY_WAIT = 11'h002,
    ST_SETTLE = 11'h004,
    ST_VIDEO_ON = 11'h008,
    ST_BL_SUPPLY_WAIT = 11'h010,
    ST_BL_SETTLE = 11'h020,
    ST_DIM_ON = 11'h040,
    ST_RUN = 11'h080,
    ST_BL_DOWN = 11'h100,
    ST_BL_SUPPLY_OFF = 11'h200,
    ST_VIDEO_OFF = 11'h400
  } pvs_state_type;

endpackage : pvs_pkg

/* File: testbench/pvs_panel_model.sv */
// Purpose: Panel-side model that reports supply good levels.
// Assumes: Each supply needs a rise time after its enable.
// Notes: A dip moves only the good pin, never panel state.
`timescale 1ns/10ps
module pvs_panel_model #(
  parameter int RISE_CLKS = 40
) (
  input wire logic clk,
  input wire logic reset,
  input wire pvs_pkg::pvs_power_type power_pins,
  input wire logic supply_dip,
  output logic logic_supply_good,
  output logic backlight_supply_good
);
  int lr_q;
  int br_q;
  // Rise timers; a disabled supply reads bad at once
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lr_q <= 0;
      br_q <= 0;
    end else begin
      lr_q <= power_pins.logic_supply_enable ? lr_q + 1 : 0;
      br_q <= power_pins.backlight_supply_enable ? br_q + 1 : 0;
    end
  end
  // Short dip is ridden through, so no state is lost
  assign logic_supply_good = lr_q > RISE_CLKS && !supply_dip;
  assign backlight_supply_good = br_q > RISE_CLKS;
endmodule : pvs_panel_model

/* File: testbench/pvs_host_properties.sv */
// Purpose: Assertions on sequencer and timing generator ports.
// Assumes: Qualifier sampled on clk is fine for ms-scale timing.
// Notes: SLACK covers the enable crossing into the pixel domain.
`timescale 1ns/10ps
module pvs_host_checker #(
  parameter int CLKS_PER_MS = pvs_pkg::CLKS_PER_MS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic pix_clk,
  input wire logic power_request,
  input wire logic [pvs_pkg::DUTY_WIDTH-1:0] dimming_duty,
  input wire logic logic_supply_good,
  input wire logic backlight_supply_good,
  input wire logic [pvs_pkg::PIXEL_WIDTH-1:0] pixel_in,
  input wire logic pixel_request,
  input wire pvs_pkg::pvs_power_type power_pins,
  input wire pvs_pkg::pvs_video_type video_out,
  input wire logic panel_ready,
  input wire logic panel_off
);
  localparam int MS = CLKS_PER_MS;
  localparam int SLACK = 24;
  int good_q, vid_q, blg_q, dim_q, dlow_q, bloff_q, run_q, low_q;
  logic seen_q, had_q;
  wire logic qual = video_out.pixel_valid_qualifier;
  // Cycles since each power event
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {good_q, vid_q, blg_q, dim_q, dlow_q, bloff_q} <= '0;
      seen_q <= 1'b0;
    end else begin
      good_q <= logic_supply_good ? good_q + 1 : 0;
      seen_q <= power_pins.logic_supply_enable && (seen_q || qual);
      vid_q <= seen_q ? vid_q + 1 : 0;
      blg_q <= backlight_supply_good ? blg_q + 1 : 0;
      dim_q <= power_pins.backlight_supply_enable && (dim_q > 0 || power_pins.backlight_dimming_pulse) ? dim_q + 1 : 0;
      dlow_q <= power_pins.backlight_dimming_pulse ? 0 : dlow_q + 1;
      bloff_q <= power_pins.backlight_supply_enable ? 0 : bloff_q + 1;
    end
  end
  // Qualifier run and gap lengths
  always_ff @(posedge pix_clk or posedge reset) begin
    if (reset) begin
      {run_q, low_q} <= '0;
      had_q <= 1'b0;
    end else begin
      run_q <= qual ? run_q + 1 : 0;
      low_q <= qual ? 0 : low_q + 1;
      had_q <= power_pins.logic_supply_enable && (had_q || (!qual && run_q > 0));
    end
  end
  supply_off_quiet_a: assert property (@(posedge clk) disable iff (reset)
    !power_pins.logic_supply_enable |-> power_pins == '0 && !qual) else $error("signals active, supply off");
  video_start_a: assert property (@(posedge clk) disable iff (reset)
    qual && !seen_q |-> good_q >= 30 * MS) else $error("video before settle");
  video_late_a: assert property (@(posedge clk) disable iff (reset)
    good_q == 90 * MS |-> seen_q) else $error("video not valid in time");
  backlight_wait_a: assert property (@(posedge clk) disable iff (reset)
    $rose(power_pins.backlight_supply_enable) |-> vid_q >= 200 * MS - SLACK) else $error("backlight early");
  dimming_wait_a: assert property (@(posedge clk) disable iff (reset)
    $rose(power_pins.backlight_dimming_pulse) |-> blg_q >= 10 * MS) else $error("dimming early");
  enable_wait_a: assert property (@(posedge clk) disable iff (reset)
    $rose(power_pins.backlight_enable_line) |-> dim_q >= 10 * MS) else $error("enable early");
  enable_pwm_a: assert property (@(posedge clk) disable iff (reset)
    power_pins.backlight_enable_line |-> power_pins.backlight_supply_enable && dlow_q <= pvs_pkg::PWM_PERIOD_CLKS)
    else $error("enable without dimming");
  bl_supply_off_a: assert property (@(posedge clk) disable iff (reset)
    $fell(power_pins.backlight_supply_enable) |-> dlow_q >= 200 * MS) else $error("supply off early");
  video_stop_a: assert property (@(posedge clk) disable iff (reset)
    $fell(power_pins.logic_supply_enable) && seen_q |-> bloff_q >= 200 * MS) else $error("video off early");
  pixel_pipe_a: assert property (@(posedge pix_clk) disable iff (reset)
    1'b1 |=> qual == $past(pixel_request) && video_out.pixel_data == ($past(pixel_request) ? $past(pixel_in) : '0))
    else $error("qualifier or data wrong");
  line_active_a: assert property (@(posedge pix_clk) disable iff (reset)
    $fell(qual) && power_request |-> run_q == pvs_pkg::ACTIVE_CLOCKS_PER_LINE) else $error("active run wrong");
  line_gap_a: assert property (@(posedge pix_clk) disable iff (reset)
    $rose(qual) && had_q |-> low_q == pvs_pkg::LINE_BLANKING_CLOCKS || low_q == pvs_pkg::LINE_BLANKING_CLOCKS
    + pvs_pkg::FRAME_BLANKING_LINES * pvs_pkg::LINE_TOTAL_CLOCKS) else $error("blanking wrong");
endmodule : pvs_host_checker
bind pvs_host pvs_host_checker #(.CLKS_PER_MS(CLKS_PER_MS)) u_chk (.clk(clk), .reset(reset), .pix_clk(pix_clk),
  .power_request(power_request), .dimming_duty(dimming_duty), .logic_supply_good(logic_supply_good),
  .backlight_supply_good(backlight_supply_good), .pixel_in(pixel_in), .pixel_request(pixel_request),
  .power_pins(power_pins), .video_out(video_out), .panel_ready(panel_ready), .panel_off(panel_off));

/* File: testbench/pvs_host_tb.sv */
// Purpose: Self-checking bench for the panel host sequencer.
// Assumes: One ms is MS control clocks.
// Notes: Pixel clock is the host synthesiser, so it runs free.
`timescale 1ns/10ps
module pvs_host_tb;
  localparam int MS = 20;
  localparam int LS = 0, EN = 1, DIM = 2, BLG = 3, BLS = 4, QV = 5, GD = 6;
  logic clk = 1'b0;
  logic pix_clk = 1'b0;
  logic reset = 1'b1;
  logic power_request = 1'b0;
  logic supply_dip = 1'b0;
  logic [9:0] dimming_duty = 10'h032;
  logic [23:0] pixel_in = 24'h000000;
  logic lsg, bsg, pixel_request, panel_ready, panel_off;
  logic [6:0] ev_q;
  pvs_pkg::pvs_power_type power_pins;
  pvs_pkg::pvs_video_type video_out;
  int t_rise[7], t_fall[7];
  int cyc = 1;
  int fail_count = 0;
  int n_compared = 0;
  wire logic [6:0] ev = {lsg, video_out.pixel_valid_qualifier, power_pins.backlight_supply_enable, bsg,
    power_pins.backlight_dimming_pulse, power_pins.backlight_enable_line, power_pins.logic_supply_enable};
  // Clocks; pixel phase offset keeps edges apart
  always #12.5 clk = ~clk;
  always begin
    #33;
    forever #40 pix_clk = ~pix_clk;
  end
  always @(negedge pix_clk) pixel_in <= pixel_in + 24'h000001;
  // First rise and last fall of each event
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ev_q <= ev;
    for (int i = 0; i < 7; i++) begin
      if (ev[i] && !ev_q[i] && t_rise[i] == 0) t_rise[i] <= cyc;
      if (!ev[i] && ev_q[i]) t_fall[i] <= cyc;
    end
  end
  pvs_host #(.CLKS_PER_MS(MS)) u_dut (.clk(clk), .reset(reset), .pix_clk(pix_clk), .power_request(power_request),
    .dimming_duty(dimming_duty), .logic_supply_good(lsg), .backlight_supply_good(bsg), .pixel_in(pixel_in),
    .pixel_request(pixel_request), .power_pins(power_pins), .video_out(video_out), .panel_ready(panel_ready),
    .panel_off(panel_off));
  pvs_panel_model u_panel (.clk(clk), .reset(reset), .power_pins(power_pins), .supply_dip(supply_dip),
    .logic_supply_good(lsg), .backlight_supply_good(bsg));
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  // Bounded wait for a recorded edge
  task automatic wait_ev(input int i, input logic fall, input int lim);
    int n;
    n = 0;
    while ((fall ? t_fall[i] : t_rise[i]) == 0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    check((fall ? t_fall[i] : t_rise[i]) != 0, "event did not come");
  endtask : wait_ev
  task automatic test_abort;
    t_rise = '{default: 0};
    power_request = 1'b1;
    wait_ev(GD, 1'b0, 100);
    repeat (5 * MS) @(negedge clk);
    power_request = 1'b0;
    repeat (8) @(negedge clk);
    check(power_pins === 4'h0 && panel_off === 1'b1 && t_rise[QV] === 0, "abort wrong");
    power_request = 1'b1;
    repeat (40 * MS) @(negedge clk);
    reset = 1'b1;
    power_request = 1'b0;
    repeat (6) @(negedge clk);
    check(power_pins === 4'h0 && video_out === 25'h0000000, "reset left pins driven");
    reset = 1'b0;
  endtask : test_abort
  task automatic test_power_up;
    t_rise = '{default: 0};
    power_request = 1'b1;
    wait_ev(GD, 1'b0, 200);
    wait_ev(QV, 1'b0, 100 * MS);
    check(t_rise[QV] - t_rise[GD] inside {[30 * MS : 90 * MS]}, "video start out of window");
    wait_ev(BLS, 1'b0, 300 * MS);
    check(t_rise[BLS] - t_rise[QV] >= 200 * MS - 24, "backlight early");
    wait_ev(BLG, 1'b0, 100);
    wait_ev(DIM, 1'b0, 50 * MS);
    check(t_rise[DIM] - t_rise[BLG] >= 10 * MS, "dimming early");
    wait_ev(EN, 1'b0, 50 * MS);
    check(t_rise[EN] - t_rise[DIM] >= 10 * MS, "enable early");
    repeat (2) @(negedge clk);
    check(panel_ready === 1'b1 && panel_off === 1'b0, "not ready");
  endtask : test_power_up
  // Measures one full dimming period
  task automatic pwm_high(input int exp);
    int hi, lo;
    hi = 0;
    lo = 0;
    repeat (4000) if (power_pins.backlight_dimming_pulse !== 1'b0) @(negedge clk);
    repeat (4000) if (power_pins.backlight_dimming_pulse !== 1'b1) @(negedge clk);
    while (power_pins.backlight_dimming_pulse === 1'b1 && hi < 4000) begin
      @(negedge clk);
      hi++;
    end
    while (power_pins.backlight_dimming_pulse === 1'b0 && lo < 4000) begin
      @(negedge clk);
      lo++;
    end
    check(hi == exp && hi + lo == pvs_pkg::PWM_PERIOD_CLKS, "dimming duty wrong");
  endtask : pwm_high
  task automatic test_run;
    int hi, lo;
    hi = 0;
    lo = 0;
    supply_dip = 1'b1;
    repeat (5 * MS) @(negedge clk);
    supply_dip = 1'b0;
    check(panel_ready === 1'b1 && power_pins.backlight_enable_line === 1'b1, "dip disturbed host");
    pwm_high(pvs_pkg::DIMMING_DUTY_MIN_PERMILLE * pvs_pkg::PWM_CLKS_PER_PERMILLE);
    dimming_duty = 10'h1F4;
    pwm_high(500 * pvs_pkg::PWM_CLKS_PER_PERMILLE);
    repeat (2000) if (video_out.pixel_valid_qualifier !== 1'b1) @(negedge pix_clk);
    repeat (2000) if (video_out.pixel_valid_qualifier !== 1'b0) @(negedge pix_clk);
    check(video_out.pixel_data === 24'h000000, "blank data not zero");
    while (video_out.pixel_valid_qualifier === 1'b0 && lo < 2000) begin
      @(negedge pix_clk);
      lo++;
    end
    check(video_out.pixel_data === pixel_in, "pixel data not passed");
    while (video_out.pixel_valid_qualifier === 1'b1 && hi < 2000) begin
      @(negedge pix_clk);
      hi++;
    end
    check(lo == pvs_pkg::LINE_BLANKING_CLOCKS && hi == pvs_pkg::ACTIVE_CLOCKS_PER_LINE, "line wrong");
  endtask : test_run
  task automatic test_power_down;
    t_rise = '{default: 0};
    t_fall = '{default: 0};
    @(negedge clk);
    power_request = 1'b0;
    wait_ev(EN, 1'b1, 10);
    wait_ev(BLS, 1'b1, 300 * MS);
    check(t_rise[DIM] === 0 && t_fall[BLS] - t_fall[EN] >= 200 * MS, "bl supply off early");
    wait_ev(LS, 1'b1, 300 * MS);
    check(t_fall[LS] - t_fall[BLS] inside {[200 * MS : 250 * MS]}, "supply off timing");
    repeat (2) @(negedge clk);
    check(video_out === 25'h0000000 && panel_off === 1'b1, "signals left driven");
  endtask : test_power_down
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    check(panel_off === 1'b1 && power_pins === 4'h0 && video_out === 25'h0000000, "reset state");
    test_abort();
    test_power_up();
    test_run();
    test_power_down();
    end_of_test();
  end
  // Watchdog, well past the expected run
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule : pvs_host_tb
